// [rtl/vcts_regs.svh]
`ifndef VCTS_REGS_SVH
`define VCTS_REGS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define VCTS_OFS_CTRL       8'h00
`define VCTS_OFS_IMPSCALE   8'h04
`define VCTS_OFS_TXPCM      8'h08
`define VCTS_OFS_IRQ_STAT   8'h0C
`define VCTS_OFS_IRQ_MASK   8'h10
`define VCTS_OFS_STATE      8'h14

// ------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------
`define VCTS_CTRL_W         10
`define VCTS_B_TX_CUT       0
`define VCTS_B_RX_CUT       1
`define VCTS_B_HPF_DIS      2
`define VCTS_B_RX_LOSS      3
`define VCTS_B_IRQ_ARM      4
`define VCTS_B_ILB          5
`define VCTS_B_FDL          6
`define VCTS_B_TLB          7
`define VCTS_B_TONE         8
`define VCTS_B_ALAW         9
`define VCTS_CTRL_RST       10'h000
`define VCTS_IMP_RST        5'h00
`define VCTS_IMP_FDL_CODE   5'h10
`define VCTS_IRQ_RST        1'h0
`define VCTS_ALAW_EVEN_MASK 8'h55

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define VCTS_CLK_NS         100
`define VCTS_SAMPLE_NS      125000
`define VCTS_DIV_CYCLES     (`VCTS_SAMPLE_NS / `VCTS_CLK_NS)

`endif

// [rtl/vcts_pkg.sv]
package vcts_pkg;

    // Linear 13-bit two's complement sample, full scale 4096 units.
    typedef logic signed [12:0] vcts_sample_t;
    typedef logic [7:0]         vcts_code_t;

endpackage

// [rtl/vcts_alaw_enc.sv]
`timescale 1ns/1ps
`include "vcts_regs.svh"

module vcts_alaw_enc
    import vcts_pkg::*;
(
    input  wire vcts_sample_t lin_in,
    output vcts_code_t        code_out
);

    logic        neg;
    logic [12:0] mag13;
    logic [11:0] mag;
    logic [2:0]  seg;
    logic [3:0]  step;

    always_comb begin
        neg   = lin_in[12];
        mag13 = neg ? 13'(-lin_in) : 13'(lin_in);
        mag   = mag13[12] ? 12'hFFF : mag13[11:0];
        casez (mag[11:5])
            7'b1??????: begin seg = 3'h7; step = mag[10:7]; end
            7'b01?????: begin seg = 3'h6; step = mag[9:6]; end
            7'b001????: begin seg = 3'h5; step = mag[8:5]; end
            7'b0001???: begin seg = 3'h4; step = mag[7:4]; end
            7'b00001??: begin seg = 3'h3; step = mag[6:3]; end
            7'b000001?: begin seg = 3'h2; step = mag[5:2]; end
            7'b0000001: begin seg = 3'h1; step = mag[4:1]; end
            default:    begin seg = 3'h0; step = mag[4:1]; end
        endcase
        // Sign bit is 0 for negative input; even bits are then inverted.
        code_out = {~neg, seg, step} ^ `VCTS_ALAW_EVEN_MASK;
    end

endmodule

// [rtl/vcts_top.sv]
// Notes on behaviour
// - Transmit cutoff floats data and buffer control.
// - Transmit cutoff overrides both loopback states.
// - Receive cutoff zeroes signal before lowpass stage.
// - Receive cutoff blocks digital loopback, tone, balance.
// - Highpass disable bypasses transmit highpass, notch.
// - Extra receive loss attenuates by 6.02 dB.
// - Parallel mode host reads current transmit code.
// - Armed interrupt on new data, cleared by read.
// - Interface loopback sends receive data upstream.
// - Full loopback mutes output, feeds it back.
// - Impedance code 10000 also enters full loopback.
// - Tone bit injects 1 kHz milliwatt on receive.
// - A-law companding over 4096 units.
// - Even bits of A-law character inverted.
// - Sign bit zero for negative samples.
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "vcts_regs.svh"

module vcts_top
    import vcts_pkg::*;
(
    input  wire logic         CLOCK_IN,
    input  wire logic         RST_B_IN,
    input  wire logic         HSEL_IN,
    input  wire logic [31:0]  HADDR_IN,
    input  wire logic [1:0]   HTRANS_IN,
    input  wire logic         HWRITE_IN,
    input  wire logic [2:0]   HSIZE_IN,
    input  wire logic [31:0]  HWDATA_IN,
    input  wire logic         HREADY_IN,
    output logic      [31:0]  HRDATA_OUT,
    output logic              HREADYOUT_OUT,
    output logic              HRESP_OUT,
    input  wire logic         MPI_MODE_IN,
    input  wire vcts_sample_t RX_SAMPLE_IN,
    input  wire vcts_code_t   RX_PCM_IN,
    input  wire vcts_sample_t TX_ANALOG_IN,
    input  wire logic         TX_SLOT_IN,
    output vcts_sample_t      RX_LPF_OUT,
    output vcts_code_t        PCM_TX_OUT,
    output logic              PCM_TX_OE_OUT,
    output logic              SLOT_BUF_CTRL_N_OUT,
    output logic              SLOT_BUF_CTRL_OE_OUT,
    output logic              TX_HPF_BYPASS_OUT,
    output logic              ANALOG_OUT_EN_OUT,
    output logic              IMPEDANCE_SCALING_EN_OUT,
    output logic              B_FILTER_EN_OUT,
    output logic              SAMPLE_TICK_OUT,
    output logic              IRQ_OUT
);

    logic [`VCTS_CTRL_W-1:0] ctrl_reg;
    logic [4:0]              imp_reg;
    logic                    irq_stat_reg;
    logic                    irq_mask_reg;
    logic [10:0]             div_reg;
    logic                    tick_reg;
    logic [2:0]              tone_ph_reg;
    logic [2:0]              mode_sync_reg;
    logic                    mode_reg;
    logic                    dph_wr_reg;
    logic [7:0]              dph_addr_reg;
    vcts_sample_t            rx_reg;
    vcts_code_t              tx_code_reg;

    logic         tx_cut, rx_cut, interface_loopback, slot_assigner_loopback, tone, fdl_eff;
    logic         acc, rd_acc, readout;
    logic [31:0]  rdata_next;
    vcts_sample_t tone_val, rx_src, rx_next, tx_lin;
    vcts_code_t   enc_code, tx_code_next;

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    assign tx_cut  = ctrl_reg[`VCTS_B_TX_CUT];
    assign rx_cut  = ctrl_reg[`VCTS_B_RX_CUT];
    assign interface_loopback     = ctrl_reg[`VCTS_B_ILB];
    assign slot_assigner_loopback     = ctrl_reg[`VCTS_B_TLB];
    assign tone    = ctrl_reg[`VCTS_B_TONE];
    assign fdl_eff = ctrl_reg[`VCTS_B_FDL] | (imp_reg == `VCTS_IMP_FDL_CODE);

    // ------------------------------------------------------------
    // Sample rate divider
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            div_reg  <= 11'h000;
            tick_reg <= 1'b0;
        end else if (div_reg == 11'(`VCTS_DIV_CYCLES - 1)) begin
            div_reg  <= 11'h000;
            tick_reg <= 1'b1;
        end else begin
            div_reg  <= div_reg + 11'h001;
            tick_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Mode pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            mode_sync_reg <= 3'h0;
            mode_reg      <= 1'b0;
        end else begin
            mode_sync_reg <= {mode_sync_reg[1:0], MPI_MODE_IN};
            if (mode_sync_reg[1] == mode_sync_reg[2]) begin
                mode_reg <= mode_sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // Register bus slave
    // ------------------------------------------------------------
    assign acc     = HSEL_IN & HREADY_IN & HTRANS_IN[1];
    assign rd_acc  = acc & ~HWRITE_IN;
    assign readout = rd_acc & mode_reg & (HADDR_IN[7:0] == `VCTS_OFS_TXPCM);

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (HADDR_IN[7:0])
            `VCTS_OFS_CTRL:     rdata_next = {22'h000000, ctrl_reg};
            `VCTS_OFS_IMPSCALE: rdata_next = {27'h0000000, imp_reg};
            `VCTS_OFS_TXPCM:    rdata_next = {24'h000000, mode_reg ? tx_code_reg : 8'h00};
            `VCTS_OFS_IRQ_STAT: rdata_next = {31'h00000000, irq_stat_reg};
            `VCTS_OFS_IRQ_MASK: rdata_next = {31'h00000000, irq_mask_reg};
            `VCTS_OFS_STATE:    rdata_next = {29'h00000000, mode_reg, ~rx_cut, fdl_eff};
            default:            rdata_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            HRDATA_OUT    <= 32'h0000_0000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
            dph_wr_reg    <= 1'b0;
            dph_addr_reg  <= 8'h00;
        end else begin
            dph_wr_reg <= acc & HWRITE_IN;
            if (acc) begin
                dph_addr_reg <= HADDR_IN[7:0];
            end
            if (rd_acc) begin
                HRDATA_OUT <= rdata_next;
            end
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ctrl_reg     <= `VCTS_CTRL_RST;
            imp_reg      <= `VCTS_IMP_RST;
            irq_mask_reg <= 1'b0;
        end else if (dph_wr_reg) begin
            case (dph_addr_reg)
                `VCTS_OFS_CTRL:     ctrl_reg     <= HWDATA_IN[`VCTS_CTRL_W-1:0];
                `VCTS_OFS_IMPSCALE: imp_reg      <= HWDATA_IN[4:0];
                `VCTS_OFS_IRQ_MASK: irq_mask_reg <= HWDATA_IN[0];
                default:            ctrl_reg     <= ctrl_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transmit data interrupt
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            irq_stat_reg <= `VCTS_IRQ_RST;
        end else if (tick_reg & ctrl_reg[`VCTS_B_IRQ_ARM]) begin
            irq_stat_reg <= 1'b1;
        end else if (readout) begin
            irq_stat_reg <= 1'b0;
        end else if (dph_wr_reg && dph_addr_reg == `VCTS_OFS_IRQ_STAT && HWDATA_IN[0]) begin
            irq_stat_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= irq_stat_reg & irq_mask_reg;
        end
    end

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    always_comb begin
        case (tone_ph_reg)
            3'h0:    tone_val = 13'sd0;
            3'h1:    tone_val = 13'sd2017;
            3'h2:    tone_val = 13'sd2852;
            3'h3:    tone_val = 13'sd2017;
            3'h4:    tone_val = 13'sd0;
            3'h5:    tone_val = -13'sd2017;
            3'h6:    tone_val = -13'sd2852;
            default: tone_val = -13'sd2017;
        endcase
        rx_src = tone ? tone_val : RX_SAMPLE_IN;
        if (rx_cut) begin
            rx_next = 13'sd0;
        end else if (ctrl_reg[`VCTS_B_RX_LOSS]) begin
            rx_next = rx_src >>> 1;
        end else begin
            rx_next = rx_src;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tone_ph_reg <= 3'h0;
            rx_reg      <= 13'sd0;
        end else if (tick_reg) begin
            tone_ph_reg <= tone_ph_reg + 3'h1;
            rx_reg      <= rx_next;
        end
    end

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    always_comb begin
        if (interface_loopback) begin
            tx_lin = RX_SAMPLE_IN;
        end else if (fdl_eff) begin
            tx_lin = rx_cut ? 13'sd0 : rx_reg;
        end else begin
            tx_lin = TX_ANALOG_IN;
        end
        if (slot_assigner_loopback && !interface_loopback) begin
            tx_code_next = RX_PCM_IN;
        end else if (ctrl_reg[`VCTS_B_ALAW]) begin
            tx_code_next = enc_code;
        end else begin
            tx_code_next = tx_lin[12:5];
        end
    end

    vcts_alaw_enc u_enc (
        .lin_in   (tx_lin),
        .code_out (enc_code)
    );

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tx_code_reg <= 8'h00;
        end else if (tick_reg) begin
            tx_code_reg <= tx_code_next;
        end
    end

    // ------------------------------------------------------------
    // Pin and path enables
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            PCM_TX_OE_OUT        <= 1'b0;
            SLOT_BUF_CTRL_N_OUT  <= 1'b1;
            SLOT_BUF_CTRL_OE_OUT <= 1'b0;
        end else begin
            PCM_TX_OE_OUT        <= TX_SLOT_IN & ~tx_cut;
            SLOT_BUF_CTRL_N_OUT  <= ~(TX_SLOT_IN & ~tx_cut);
            SLOT_BUF_CTRL_OE_OUT <= ~tx_cut;
        end
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            TX_HPF_BYPASS_OUT        <= 1'b0;
            ANALOG_OUT_EN_OUT        <= 1'b1;
            IMPEDANCE_SCALING_EN_OUT <= 1'b1;
            B_FILTER_EN_OUT          <= 1'b1;
        end else begin
            TX_HPF_BYPASS_OUT        <= ctrl_reg[`VCTS_B_HPF_DIS];
            ANALOG_OUT_EN_OUT        <= ~fdl_eff;
            IMPEDANCE_SCALING_EN_OUT <= ~fdl_eff;
            B_FILTER_EN_OUT          <= ~rx_cut;
        end
    end

    assign RX_LPF_OUT      = rx_reg;
    assign PCM_TX_OUT      = tx_code_reg;
    assign SAMPLE_TICK_OUT = tick_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_B_IN);

    a_tx_cut_float: assert property (tx_cut |=> !PCM_TX_OE_OUT && !SLOT_BUF_CTRL_OE_OUT)
        else $error("transmit pins driven during cutoff");
    a_cut_over_loop: assert property ((tx_cut && (slot_assigner_loopback || fdl_eff)) ##1 tx_cut
        |-> !PCM_TX_OE_OUT) else $error("loopback overrode transmit cutoff");
    a_rx_cut_zero: assert property (tick_reg && rx_cut |=> RX_LPF_OUT == 13'sd0)
        else $error("receive signal not zero in cutoff");
    a_rx_cut_block: assert property (rx_cut |=> !B_FILTER_EN_OUT)
        else $error("balance path active in receive cutoff");
    a_hpf_bypass: assert property ($rose(ctrl_reg[`VCTS_B_HPF_DIS]) |=> TX_HPF_BYPASS_OUT)
        else $error("highpass not bypassed");
    a_rx_loss_half: assert property (tick_reg && ctrl_reg[`VCTS_B_RX_LOSS] && !rx_cut
        && !tone |=> RX_LPF_OUT == ($past(RX_SAMPLE_IN) >>> 1)) else $error("receive loss wrong");
    a_readout_clr: assert property (readout && !tick_reg |=> !irq_stat_reg)
        else $error("readout did not clear interrupt");
    a_irq_new_data: assert property (tick_reg && ctrl_reg[`VCTS_B_IRQ_ARM]
        |=> irq_stat_reg ##1 IRQ_OUT == irq_mask_reg) else $error("new data interrupt missing");
    a_ilb_route: assert property (tick_reg && interface_loopback && !slot_assigner_loopback && !ctrl_reg[`VCTS_B_ALAW]
        |=> PCM_TX_OUT == $past(RX_SAMPLE_IN[12:5])) else $error("interface loopback wrong");
    a_fdl_code: assert property (imp_reg == `VCTS_IMP_FDL_CODE
        |=> !ANALOG_OUT_EN_OUT && !IMPEDANCE_SCALING_EN_OUT) else $error("code did not loop");
    a_tone_inject: assert property (tick_reg && tone && !rx_cut && !ctrl_reg[`VCTS_B_RX_LOSS]
        |=> RX_LPF_OUT == $past(tone_val)) else $error("tone not injected");

    c_tx_cutoff: cover property (tx_cut && TX_SLOT_IN ##1 !PCM_TX_OE_OUT);
    c_irq_readout: cover property (IRQ_OUT ##[1:20] readout);
    c_tone_loop: cover property (tick_reg && tone && fdl_eff);

endmodule

// [tb/vcts_pcm_highway.sv]
`timescale 1ns/1ps

module vcts_pcm_highway
    import vcts_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         tick_in,
    input  wire vcts_sample_t rx_val_in,
    input  wire vcts_sample_t tx_val_in,
    input  wire vcts_code_t   rx_pcm_val_in,
    output vcts_sample_t      rx_sample_out,
    output vcts_code_t        rx_pcm_out,
    output vcts_sample_t      tx_analog_out,
    output logic              tx_slot_out
);
    logic [4:0] slot_cnt_reg;

    // ------------------------------------------------------------
    // Slot timing
    // ------------------------------------------------------------
    // The channel slot opens twelve cycles after each tick rises and lasts eight cycles.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            slot_cnt_reg <= 5'h1F;
            tx_slot_out <= 1'b0;
        end else begin
            if (tick_in) begin
                slot_cnt_reg <= 5'h00;
            end else if (slot_cnt_reg != 5'h1F) begin
                slot_cnt_reg <= slot_cnt_reg + 5'h01;
            end
            tx_slot_out <= (slot_cnt_reg >= 5'h0A) && (slot_cnt_reg <= 5'h11);
        end
    end

    // ------------------------------------------------------------
    // Sample lines
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_sample_out <= 13'h0000;
            rx_pcm_out <= 8'h00;
            tx_analog_out <= 13'h0000;
        end else begin
            rx_sample_out <= rx_val_in;
            rx_pcm_out <= rx_pcm_val_in;
            tx_analog_out <= tx_val_in;
        end
    end
endmodule

// [tb/test_vcts_top.sv]
`timescale 1ns/1ps
`include "vcts_regs.svh"

module test_vcts_top
    import vcts_pkg::*;
;
    typedef struct packed {
        logic [9:0]   c;
        vcts_sample_t tx;
        vcts_sample_t rx_lowpass_stage;
        vcts_code_t   pcm;
        logic [4:0]   f;
    } vcts_row_s;

    logic              clk, rst_b, hsel, hwrite, hready, hresp, mode, slot, oe_seen;
    logic              pcm_oe, bufn, buf_oe, tx_highpass_disable, aout, imp, bfil, tick, irq;
    logic [1:0]        htrans;
    logic [31:0]       haddr, hwdata, hrdata, rdv;
    vcts_sample_t      rx_v, tx_v, rx_s, tx_a, rx_lowpass_stage;
    vcts_code_t        rxp_v, rx_p, pcm;
    int                miscompares, comparisons, cyc, hits;
    vcts_sample_t      s [8];
    vcts_sample_t      tone [8] = '{13'h0000, 13'h07E1, 13'h0B24, 13'h07E1,
                                    13'h0000, 13'h181F, 13'h14DC, 13'h181F};
    // Inputs: control word and transmit sample; outputs: receive sample, code,
    // flags {slot drive seen, bypass, analog on, scaling on, balance on}.
    vcts_row_s         rows [14] = '{
        '{10'h000, 13'h0100, 13'h0400, 8'h08, 5'h17},
        '{10'h001, 13'h0100, 13'h0400, 8'h08, 5'h07},
        '{10'h002, 13'h0100, 13'h0000, 8'h08, 5'h16},
        '{10'h004, 13'h0100, 13'h0400, 8'h08, 5'h1F},
        '{10'h008, 13'h0100, 13'h0200, 8'h08, 5'h17},
        '{10'h020, 13'h0100, 13'h0400, 8'h20, 5'h17},
        '{10'h040, 13'h0100, 13'h0400, 8'h20, 5'h11},
        '{10'h042, 13'h0100, 13'h0000, 8'h00, 5'h10},
        '{10'h080, 13'h0100, 13'h0400, 8'h20, 5'h17},
        '{10'h0C1, 13'h0100, 13'h0400, 8'h20, 5'h01},
        '{10'h102, 13'h0100, 13'h0000, 8'h08, 5'h16},
        '{10'h200, 13'h0100, 13'h0400, 8'h95, 5'h17},
        '{10'h200, 13'h0FFF, 13'h0400, 8'hAA, 5'h17},
        '{10'h200, 13'h1000, 13'h0400, 8'h2A, 5'h17}};

    vcts_top u_vcts_top (.CLOCK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .MPI_MODE_IN(mode), .RX_SAMPLE_IN(rx_s), .RX_PCM_IN(rx_p), .TX_ANALOG_IN(tx_a),
        .TX_SLOT_IN(slot), .RX_LPF_OUT(rx_lowpass_stage), .PCM_TX_OUT(pcm), .PCM_TX_OE_OUT(pcm_oe),
        .SLOT_BUF_CTRL_N_OUT(bufn), .SLOT_BUF_CTRL_OE_OUT(buf_oe), .TX_HPF_BYPASS_OUT(tx_highpass_disable),
        .ANALOG_OUT_EN_OUT(aout), .IMPEDANCE_SCALING_EN_OUT(imp), .B_FILTER_EN_OUT(bfil),
        .SAMPLE_TICK_OUT(tick), .IRQ_OUT(irq));

    vcts_pcm_highway u_vcts_pcm_highway (.clk_in(clk), .rst_b_in(rst_b), .tick_in(tick),
        .rx_val_in(rx_v), .tx_val_in(tx_v), .rx_pcm_val_in(rxp_v), .rx_sample_out(rx_s),
        .rx_pcm_out(rx_p), .tx_analog_out(tx_a), .tx_slot_out(slot));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (pcm_oe === 1'b1 && bufn === 1'b0) oe_seen <= 1'b1;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            tally_and_finish;
        end
    end

    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // One single word transfer; read data is taken at the data phase's closing edge.
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask

    task automatic wait_tick;
        do @(posedge clk); while (tick !== 1'b1);
        #1;
    endtask

    initial begin
        {hsel, hwrite, mode, oe_seen, cyc, miscompares, comparisons, hits} = '0;
        {htrans, haddr, hwdata} = '0;
        rx_v = 13'h0400;
        rxp_v = 8'h20;
        tx_v = 13'h0100;
        rst_b = 1'b0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        chk(hresp === 1'b0 && bufn === 1'b1 && irq === 1'b0 && rx_lowpass_stage === 13'h0000, "reset out");
        ahb(1'b0, `VCTS_OFS_CTRL, 32'h0);
        chk(rdv === 32'h0, "ctrl reset");
        ahb(1'b0, 8'h20, 32'h0);
        chk(rdv === 32'h0, "unmapped read");
        for (int i = 0; i < 14; i++) begin
            tx_v <= rows[i].tx;
            ahb(1'b1, `VCTS_OFS_CTRL, {22'h0, rows[i].c});
            wait_tick;
            oe_seen = 1'b0;
            wait_tick;
            repeat (30) @(posedge clk);
            #1;
            chk(rx_lowpass_stage === rows[i].rx_lowpass_stage && pcm === rows[i].pcm, $sformatf("row %0d data", i));
            rdv = {25'h0, oe_seen, tx_highpass_disable, aout, imp, bfil, buf_oe, bufn};
            chk(rdv === {25'h0, rows[i].f, rows[i].f[4], 1'b1},
                $sformatf("row %0d enables", i));
        end
        tx_v <= 13'h0100;
        ahb(1'b1, `VCTS_OFS_CTRL, 32'h0);
        ahb(1'b1, `VCTS_OFS_IMPSCALE, 32'h10);
        repeat (3) @(posedge clk);
        #1;
        chk(aout === 1'b0 && imp === 1'b0, "scaling code loopback");
        ahb(1'b0, `VCTS_OFS_STATE, 32'h0);
        chk(rdv === 32'h3, "state word");
        ahb(1'b1, `VCTS_OFS_IMPSCALE, 32'h0);
        mode <= 1'b1;
        ahb(1'b1, `VCTS_OFS_IRQ_MASK, 32'h1);
        ahb(1'b1, `VCTS_OFS_CTRL, 32'h10);
        wait_tick;
        @(posedge clk);
        #1;
        chk(irq === 1'b1, "irq set");
        ahb(1'b0, `VCTS_OFS_TXPCM, 32'h0);
        chk(rdv === 32'h08, "tx readout");
        repeat (2) @(posedge clk);
        #1;
        chk(irq === 1'b0, "irq read clear");
        ahb(1'b1, `VCTS_OFS_IRQ_MASK, 32'h0);
        wait_tick;
        repeat (3) @(posedge clk);
        #1;
        chk(irq === 1'b0, "irq masked");
        ahb(1'b0, `VCTS_OFS_IRQ_STAT, 32'h0);
        chk(rdv === 32'h1, "status set");
        ahb(1'b1, `VCTS_OFS_IRQ_STAT, 32'h1);
        ahb(1'b0, `VCTS_OFS_IRQ_STAT, 32'h0);
        chk(rdv === 32'h0, "status w1c");
        mode <= 1'b0;
        repeat (8) @(posedge clk);
        ahb(1'b0, `VCTS_OFS_TXPCM, 32'h0);
        chk(rdv === 32'h0, "readout off mode");
        ahb(1'b1, `VCTS_OFS_CTRL, 32'h100);
        wait_tick;
        wait_tick;
        for (int j = 0; j < 8; j++) begin
            wait_tick;
            s[j] = rx_lowpass_stage;
        end
        for (int k = 0; k < 8; k++) begin
            if (tone[k] === s[0] && tone[(k + 1) % 8] === s[1]) begin
                hits++;
                for (int j = 0; j < 8; j++) chk(s[j] === tone[(k + j) % 8], "tone");
            end
        end
        chk(hits == 1, "tone phase");
        chk(s[2] !== s[6] && (s[2] === 13'h0B24 || s[6] === 13'h0B24), "tone peak");
        ahb(1'b1, `VCTS_OFS_CTRL, 32'h004);
        repeat (2) @(posedge clk);
        #1;
        chk(tx_highpass_disable === 1'b1, "bypass set");
        @(negedge clk);
        rst_b = 1'b0;
        #1;
        chk(tx_highpass_disable === 1'b0 && aout === 1'b1 && buf_oe === 1'b0, "mid reset");
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        ahb(1'b0, `VCTS_OFS_CTRL, 32'h0);
        chk(rdv === 32'h0, "ctrl after reset");
        tally_and_finish;
    end
endmodule
